// File: design/fuel_cfg_pkg.sv
package fuel_cfg_pkg;
  localparam int unsigned CFG_W = 16;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned BIT_DIR_IRQ_EN = 10;
  localparam int unsigned BIT_SOFT_SLEEP = 9;
  localparam int unsigned BIT_CNT_CLEAR = 8;
  localparam int unsigned BIT_FLAGS_CLEAR = 7;
  localparam int unsigned BIT_CNT_SELECT = 6;
  localparam int unsigned BIT_ZERO_OFFSET = 5;
  localparam int unsigned BIT_CMP_ENABLE = 4;
  localparam int unsigned BIT_DIS_HI = 3;
  localparam int unsigned BIT_DIS_LO = 2;
  localparam int unsigned BIT_CHG_HI = 1;
  localparam int unsigned BIT_CHG_LO = 0;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_USED_MASK = 16'h07FF;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [7:0] OFFSET_LOW_BYTE = 8'h0A;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SOFT = 3'b010,
    ST_HARD = 3'b100
  } power_state_t;
endpackage

// File: design/gate_drive.sv
`timescale 1ns/10ps
`default_nettype none
module gate_drive (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic gate_hi,
  input wire logic gate_lo,
  input wire logic overcurrent,
  output logic gate_out
);
  logic gate_q;
  logic gate_d;
  // Trip forces gate off unless lo bit overrides; hence host keeps lo clear
  assign gate_d = gate_lo ? gate_hi : (~gate_hi & ~overcurrent);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end
  assign gate_out = gate_q;
endmodule
`default_nettype wire

// File: design/fuel_gauge_config_word.sv
// Function
// - Bit 10 enables the direction-change interrupt and resets to zero.
// - Bit 9 enters soft shutdown while set and resumes normal operation when cleared.
// - Writing one to bit 8 clears both coulomb counters.
// - Writing one to bit 7 clears the overcurrent, compare-hit and flow-reversal flags.
// - Bit 6 selects the charge counter when set and the discharge counter when clear.
// - Bit 5 ties the sense input to analog ground instead of the external circuit.
// - Bit 4 enables the digital compare function.
// - Bits 3 and 2 set the discharge gate; the host keeps bit 2 clear.
// - Bits 1 and 0 set the charge gate; the host keeps bit 0 clear.
// - In offset-measurement mode sense current does not advance either counter.
// - Overcurrent comparators keep working and tripping in offset-measurement mode.
// - In hard shutdown the device ignores the bus until the shutdown pin returns high.
// - The counter-select echo status bit follows configuration bit 6.
// - The flow-reversal flag is also cleared while the soft-shutdown bit is set.
`timescale 1ns/10ps
`default_nettype none
module fuel_gauge_config_word (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic config_write_command,
  input wire logic [15:0] config_wdata,
  input wire logic shutdown_pin,
  input wire logic charge_pulse,
  input wire logic discharge_pulse,
  input wire logic discharge_overcurrent,
  input wire logic charge_overcurrent,
  input wire logic compare_match,
  input wire logic flow_reversed,
  output logic direction_irq_enable,
  output logic soft_sleep_active,
  output logic zero_offset_measure,
  output logic compare_enable,
  output logic counter_select,
  output logic [31:0] counter_read,
  output logic [31:0] charge_coulomb_total,
  output logic [31:0] discharge_coulomb_total,
  output logic discharge_overcurrent_flag,
  output logic charge_overcurrent_flag,
  output logic compare_hit_flag,
  output logic flow_reversal_flag,
  output logic counter_select_echo,
  output logic hard_shutdown,
  output logic discharge_gate_out,
  output logic charge_gate_out
);
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [31:0] chg_q;
  logic [31:0] chg_d;
  logic [31:0] dis_q;
  logic [31:0] dis_d;
  logic odf_q;
  logic ocf_q;
  logic cmpf_q;
  logic dirf_q;
  logic odf_d;
  logic ocf_d;
  logic cmpf_d;
  logic dirf_d;
  logic shutdown_pin_s1_q;
  logic shutdown_pin_s2_q;
  logic [2:0] async_s1_q;
  logic [2:0] async_s2_q;
  logic clr_cnt_pulse_q;
  logic clr_flag_pulse_q;
  fuel_cfg_pkg::power_state_t state_q;
  fuel_cfg_pkg::power_state_t state_d;
  wire write_ok;
  wire soft_bit;
  wire offset_bit;
  wire cnt_clear;
  wire flag_clear;
  wire count_en;
  wire chg_ev;
  wire dis_ev;
  wire od_ev;
  wire oc_ev;

  function automatic logic [31:0] count_next(input logic [31:0] cur, input logic clr,
                                             input logic inc);
    count_next = clr ? fuel_cfg_pkg::CNT_ZERO : (inc ? cur + fuel_cfg_pkg::CNT_ONE : cur);
  endfunction

  // Shutdown pin, both overcurrent inputs and flow_reversed are synchronised; charge/discharge pulses come from on-chip logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shutdown_pin_s1_q <= 1'b1;
      shutdown_pin_s2_q <= 1'b1;
    end else begin
      shutdown_pin_s1_q <= shutdown_pin;
      shutdown_pin_s2_q <= shutdown_pin_s1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      async_s1_q <= 3'h0;
      async_s2_q <= 3'h0;
    end else begin
      async_s1_q <= {discharge_overcurrent, charge_overcurrent, flow_reversed};
      async_s2_q <= async_s1_q;
    end
  end
  assign od_ev = async_s2_q[2];
  assign oc_ev = async_s2_q[1];

  // Bus writes dropped in hard shutdown
  assign write_ok = config_write_command & (state_q != fuel_cfg_pkg::ST_HARD);
  // Unused top bits never stored
  assign cfg_d = write_ok ? (config_wdata & fuel_cfg_pkg::CFG_USED_MASK) : cfg_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= fuel_cfg_pkg::CFG_RESET;
      clr_cnt_pulse_q <= 1'b0;
      clr_flag_pulse_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      clr_cnt_pulse_q <= write_ok & config_wdata[fuel_cfg_pkg::BIT_CNT_CLEAR];
      clr_flag_pulse_q <= write_ok & config_wdata[fuel_cfg_pkg::BIT_FLAGS_CLEAR];
    end
  end

  assign soft_bit = cfg_q[fuel_cfg_pkg::BIT_SOFT_SLEEP];
  assign offset_bit = cfg_q[fuel_cfg_pkg::BIT_ZERO_OFFSET];
  assign direction_irq_enable = cfg_q[fuel_cfg_pkg::BIT_DIR_IRQ_EN];
  assign zero_offset_measure = offset_bit;
  assign compare_enable = cfg_q[fuel_cfg_pkg::BIT_CMP_ENABLE];
  assign counter_select = cfg_q[fuel_cfg_pkg::BIT_CNT_SELECT];
  assign counter_select_echo = counter_select;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fuel_cfg_pkg::ST_RUN: begin
        if (!shutdown_pin_s2_q) begin
          state_d = fuel_cfg_pkg::ST_HARD;
        end else if (soft_bit) begin
          state_d = fuel_cfg_pkg::ST_SOFT;
        end
      end
      fuel_cfg_pkg::ST_SOFT: begin
        if (!shutdown_pin_s2_q) begin
          state_d = fuel_cfg_pkg::ST_HARD;
        end else if (!soft_bit) begin
          state_d = fuel_cfg_pkg::ST_RUN;
        end
      end
      fuel_cfg_pkg::ST_HARD: begin
        if (shutdown_pin_s2_q) begin
          state_d = soft_bit ? fuel_cfg_pkg::ST_SOFT : fuel_cfg_pkg::ST_RUN;
        end
      end
      default: state_d = fuel_cfg_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= fuel_cfg_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end
  assign soft_sleep_active = (state_q == fuel_cfg_pkg::ST_SOFT);
  assign hard_shutdown = (state_q == fuel_cfg_pkg::ST_HARD);

  // Counting stops in offset mode because sense input is grounded
  assign count_en = (state_q == fuel_cfg_pkg::ST_RUN) & ~offset_bit;
  assign chg_ev = count_en & charge_pulse;
  assign dis_ev = count_en & discharge_pulse;
  assign cnt_clear = clr_cnt_pulse_q;
  assign chg_d = count_next(chg_q, cnt_clear, chg_ev);
  assign dis_d = count_next(dis_q, cnt_clear, dis_ev);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chg_q <= fuel_cfg_pkg::CNT_ZERO;
      dis_q <= fuel_cfg_pkg::CNT_ZERO;
      counter_read <= fuel_cfg_pkg::CNT_ZERO;
    end else begin
      chg_q <= chg_d;
      dis_q <= dis_d;
      counter_read <= counter_select ? chg_d : dis_d;
    end
  end
  assign charge_coulomb_total = chg_q;
  assign discharge_coulomb_total = dis_q;

  // Set wins over clear so a trip in the clear cycle is kept
  assign flag_clear = clr_flag_pulse_q | soft_bit;
  assign odf_d = od_ev | (odf_q & ~flag_clear);
  assign ocf_d = oc_ev | (ocf_q & ~flag_clear);
  assign cmpf_d = (compare_match & compare_enable) | (cmpf_q & ~flag_clear);
  assign dirf_d = (async_s2_q[0] & ~soft_bit) | (dirf_q & ~flag_clear);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      odf_q <= 1'b0;
      ocf_q <= 1'b0;
      cmpf_q <= 1'b0;
      dirf_q <= 1'b0;
    end else begin
      odf_q <= odf_d;
      ocf_q <= ocf_d;
      cmpf_q <= cmpf_d;
      dirf_q <= dirf_d;
    end
  end
  assign discharge_overcurrent_flag = odf_q;
  assign charge_overcurrent_flag = ocf_q;
  assign compare_hit_flag = cmpf_q;
  assign flow_reversal_flag = dirf_q;

  // Comparators stay live in offset mode
  gate_drive u_dis_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .gate_hi(cfg_q[fuel_cfg_pkg::BIT_DIS_HI]),
    .gate_lo(cfg_q[fuel_cfg_pkg::BIT_DIS_LO]),
    .overcurrent(od_ev),
    .gate_out(discharge_gate_out)
  );
  gate_drive u_chg_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .gate_hi(cfg_q[fuel_cfg_pkg::BIT_CHG_HI]),
    .gate_lo(cfg_q[fuel_cfg_pkg::BIT_CHG_LO]),
    .overcurrent(oc_ev),
    .gate_out(charge_gate_out)
  );

  AST_CFG_RESET: assert property (@(posedge sys_clk) $past(rst) |-> !direction_irq_enable)
    else $error("irq enable not clear after reset");
  AST_IRQ_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
    write_ok |=> direction_irq_enable == $past(config_wdata[fuel_cfg_pkg::BIT_DIR_IRQ_EN]))
    else $error("irq enable not taken from write");
  AST_HARD_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
    hard_shutdown |=> $stable(cfg_q))
    else $error("config changed in hard shutdown");
  AST_HARD_ENTER: assert property (@(posedge sys_clk) disable iff (rst)
    !shutdown_pin_s2_q |=> hard_shutdown)
    else $error("hard shutdown not entered");
  AST_HARD_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
    hard_shutdown && shutdown_pin_s2_q |=> !hard_shutdown)
    else $error("hard shutdown not left");
  // Clear strobes act one edge after the write, so the checks look two edges on
  sequence cnt_clear_write_s;
    write_ok && config_wdata[fuel_cfg_pkg::BIT_CNT_CLEAR] ##1 cnt_clear;
  endsequence
  sequence flags_clear_write_s;
    write_ok && config_wdata[fuel_cfg_pkg::BIT_FLAGS_CLEAR] ##1 (!od_ev && !oc_ev) [*2];
  endsequence
  AST_CNT_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_clear_write_s |=> (charge_coulomb_total == fuel_cfg_pkg::CNT_ZERO) &&
    (discharge_coulomb_total == fuel_cfg_pkg::CNT_ZERO))
    else $error("counters not cleared");
  AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    flags_clear_write_s |-> !discharge_overcurrent_flag && !charge_overcurrent_flag)
    else $error("flag not cleared");
  AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (rst)
    od_ev |=> discharge_overcurrent_flag)
    else $error("discharge trip not flagged");
  AST_SELECT: assert property (@(posedge sys_clk) disable iff (rst)
    counter_select ##1 counter_select |-> counter_read == $past(chg_d))
    else $error("wrong counter selected");
  AST_READ_DIS: assert property (@(posedge sys_clk) disable iff (rst)
    !counter_select ##1 !counter_select |-> counter_read == $past(dis_d))
    else $error("discharge counter not selected");
  AST_OFFSET_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    zero_offset_measure && !cnt_clear |=> $stable(charge_coulomb_total))
    else $error("counter moved in offset mode");
  AST_OFFSET_DIS: assert property (@(posedge sys_clk) disable iff (rst)
    zero_offset_measure && !cnt_clear |=> $stable(discharge_coulomb_total))
    else $error("discharge counter moved in offset mode");
  AST_OC_TRIP: assert property (@(posedge sys_clk) disable iff (rst)
    oc_ev && !cfg_q[fuel_cfg_pkg::BIT_CHG_LO] |=> !charge_gate_out)
    else $error("charge gate not tripped");
  AST_OD_TRIP: assert property (@(posedge sys_clk) disable iff (rst)
    od_ev && !cfg_q[fuel_cfg_pkg::BIT_DIS_LO] |=> !discharge_gate_out)
    else $error("discharge gate not tripped");
  AST_CMP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !compare_enable && !compare_hit_flag |=> !compare_hit_flag)
    else $error("compare flag set while disabled");
  AST_ECHO: assert property (@(posedge sys_clk) disable iff (rst)
    write_ok |=> counter_select_echo == $past(config_wdata[fuel_cfg_pkg::BIT_CNT_SELECT]))
    else $error("echo mismatch");
  AST_SOFT_DIR: assert property (@(posedge sys_clk) disable iff (rst)
    soft_bit |=> !flow_reversal_flag)
    else $error("flow flag kept in soft shutdown");
  AST_SOFT_ENTER: assert property (@(posedge sys_clk) disable iff (rst)
    soft_bit && shutdown_pin_s2_q && !hard_shutdown |=> soft_sleep_active)
    else $error("soft shutdown not entered");
  AST_SOFT_LEAVE: assert property (@(posedge sys_clk) disable iff (rst)
    !soft_bit && shutdown_pin_s2_q && !hard_shutdown |=> !soft_sleep_active)
    else $error("soft shutdown not left");
  AST_UNUSED: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg_q & ~fuel_cfg_pkg::CFG_USED_MASK) == 16'h0000)
    else $error("unused bits stored");
endmodule
`default_nettype wire

// File: sim/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic config_write_command,
  output logic [15:0] config_wdata
);
  initial begin
    config_write_command = 1'b0;
    config_wdata = 16'h0000;
  end
  // One whole word per strobe; data is inverted once released so stale values never match
  task automatic send(input logic [15:0] w);
    @(negedge sys_clk);
    config_write_command = 1'b1;
    config_wdata = w;
    @(negedge sys_clk);
    config_write_command = 1'b0;
    config_wdata = ~w;
  endtask
endmodule
`default_nettype wire

// File: sim/fuel_gauge_config_word_test.sv
`timescale 1ns/10ps
`default_nettype none
module fuel_gauge_config_word_test;
  logic sys_clk, rst, config_write_command, shutdown_pin, charge_pulse, discharge_pulse;
  logic discharge_overcurrent, charge_overcurrent, compare_match, flow_reversed;
  logic [15:0] config_wdata;
  logic direction_irq_enable, soft_sleep_active, zero_offset_measure, compare_enable;
  logic counter_select, discharge_overcurrent_flag, charge_overcurrent_flag, compare_hit_flag;
  logic flow_reversal_flag, counter_select_echo, hard_shutdown;
  logic discharge_gate_out, charge_gate_out;
  logic [31:0] counter_read, charge_coulomb_total, discharge_coulomb_total;
  logic [7:0] cfg_view;
  logic [3:0] flag_view;
  int error_cnt = 0;
  int num_checks = 0;
  // Word, then irq en, sleep, offset, compare, select, echo, discharge gate, charge gate
  logic [23:0] rows [7] = '{24'h04_0083, 24'h02_0043, 24'h00_2A20, 24'h00_1013,
                            24'h00_400F, 24'hF8_0F03, 24'h00_0500};
  assign cfg_view = {direction_irq_enable, soft_sleep_active, zero_offset_measure,
                     compare_enable, counter_select, counter_select_echo,
                     discharge_gate_out, charge_gate_out};
  assign flag_view = {discharge_overcurrent_flag, charge_overcurrent_flag,
                      compare_hit_flag, flow_reversal_flag};
  fuel_gauge_config_word i_dut (.sys_clk, .rst, .config_write_command, .config_wdata,
    .shutdown_pin, .charge_pulse, .discharge_pulse, .discharge_overcurrent,
    .charge_overcurrent, .compare_match, .flow_reversed, .direction_irq_enable,
    .soft_sleep_active, .zero_offset_measure, .compare_enable, .counter_select,
    .counter_read, .charge_coulomb_total, .discharge_coulomb_total,
    .discharge_overcurrent_flag, .charge_overcurrent_flag, .compare_hit_flag,
    .flow_reversal_flag, .counter_select_echo, .hard_shutdown, .discharge_gate_out,
    .charge_gate_out);
  host_model i_host (.sys_clk, .config_write_command, .config_wdata);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Four cycles cover the register stage plus the registered gate drive
  task automatic wr(input logic [15:0] w);
    i_host.send(w);
    tk(4);
  endtask
  // Async inputs are held long enough to pass the two-flop synchroniser
  task automatic hit(ref logic s, input int width);
    s = 1'b1;
    tk(width);
    s = 1'b0;
    tk(4);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst, shutdown_pin} = 2'b11;
    {charge_pulse, discharge_pulse, discharge_overcurrent} = 3'b000;
    {charge_overcurrent, compare_match, flow_reversed} = 3'b000;
    tk(3);
    rst = 1'b0;
    tk(1);
    // Both gates turn on at the first edge after reset, as all control bits are clear
    chk("cfg reset", 32'h0000_0060, {cfg_view, flag_view, hard_shutdown});
    chk("counters reset", 32'h0000_0000, charge_coulomb_total | discharge_coulomb_total);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i][23:8]);
      chk("cfg row", 32'(rows[i][7:0]), 32'(cfg_view));
    end
    $display("test table done");
    wr(16'h0040);
    repeat (3) hit(charge_pulse, 1);
    repeat (2) hit(discharge_pulse, 1);
    chk("charge total", 32'h0000_0003, charge_coulomb_total);
    chk("read charge", 32'h0000_0003, counter_read);
    wr(16'h0000);
    chk("read discharge", 32'h0000_0002, counter_read);
    wr(16'h0020);
    repeat (2) hit(charge_pulse, 1);
    chk("offset count", 32'h0000_0003, charge_coulomb_total);
    charge_overcurrent = 1'b1;
    tk(5);
    chk("trip in offset", 32'h0000_0001, {charge_gate_out, charge_overcurrent_flag});
    charge_overcurrent = 1'b0;
    $display("test counting done");
    wr(16'h0010);
    hit(compare_match, 1);
    hit(flow_reversed, 4);
    hit(discharge_overcurrent, 4);
    chk("flags set", 32'h0000_000F, flag_view);
    wr(16'h0080);
    chk("flags cleared", 32'h0000_0000, flag_view);
    hit(compare_match, 1);
    chk("compare off", 32'h0000_0000, flag_view);
    wr(16'h0100);
    chk("counters cleared", 32'h0000_0000, charge_coulomb_total | discharge_coulomb_total);
    hit(flow_reversed, 4);
    wr(16'h0200);
    chk("flow in sleep", 32'h0000_0002, {soft_sleep_active, flow_reversal_flag});
    $display("test flags done");
    wr(16'h0000);
    shutdown_pin = 1'b0;
    tk(5);
    chk("hard entered", 32'h0000_0001, hard_shutdown);
    wr(16'h0040);
    chk("write ignored", 32'h0000_0000, counter_select);
    shutdown_pin = 1'b1;
    tk(5);
    wr(16'h0040);
    chk("wake", 32'h0000_0001, {hard_shutdown, counter_select});
    $display("test shutdown done");
    wr(16'h0440);
    rst = 1'b1;
    tk(3);
    rst = 1'b0;
    tk(1);
    chk("mid reset", 32'h0000_0003, cfg_view);
    $display("test mid reset done");
    conclude;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #50us;
    error_cnt++;
    conclude;
  end
endmodule
`default_nettype wire
